// ### hdl/fifo_buf.sv
`timescale 1ns/1ps
module fifo_buf #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 4
) (
    input  logic             i_ref_clk,
    input  logic             i_rstn,
    input  logic             i_valid,
    output logic             o_ready,
    input  logic [WIDTH-1:0] i_data,
    output logic             o_valid,
    input  logic             i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0]      count, next_count;
    logic             push, pop;

    // Honest flags from the fill count
    assign o_ready = (count != (AW+1)'(DEPTH));
    assign o_valid = (count != '0);
    assign o_data  = mem[rd_ptr];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    // Pointer and count update, wrapping at depth
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
        end
        next_count = count;
        if (push && !pop) begin
            next_count = (AW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (AW+1)'(count - 1'b1);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage needs no reset; reads are gated by the count
    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end

endmodule // fifo_buf

// ### hdl/phy_mii_port.sv
`timescale 1ns/1ps
module phy_mii_port #(
    parameter int MGMT_WAIT_CYC = phy_port_pkg::MGMT_WAIT_DEF
) (
    input  logic                   i_ref_clk,
    input  logic                   i_rstn,
    input  logic                   i_crystal_clock_input,
    input  phy_port_pkg::strap_t   i_strap,
    input  logic                   i_link_up,
    input  logic                   i_link_speed_100,
    input  logic [3:0]             i_mac_txd,
    input  logic                   i_mac_tx_en,
    output logic                   o_mii_tx_clk,
    output logic                   o_mii_rx_clk,
    output logic                   o_rmii_ref_clk,
    output phy_port_pkg::mii_rx_t  o_mii_rx,
    output logic                   o_crs,
    output phy_port_pkg::line_nib_t o_line_tx,
    output logic                   o_line_tx_valid,
    input  logic                   i_line_carrier,
    input  logic                   i_line_rx_valid,
    input  phy_port_pkg::line_nib_t i_line_rx,
    output logic                   o_line_rx_ready,
    output logic                   o_led_speed,
    output logic                   o_led_speed_oe_n,
    output logic                   o_mgmt_ready
);
    import phy_port_pkg::*;

    localparam int SW = 9;

    logic [SW-1:0] sync1, sync2;
    logic          xtal_s, xtal_d, tx_en_s;
    logic [3:0]    txd_s;
    strap_t        strap_s;

    // Two-flop synchronisers for the crystal, MAC transmit and strap inputs
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1  <= '0;
            sync2  <= '0;
            xtal_d <= 1'b0;
        end else begin
            sync1  <= {i_crystal_clock_input, i_mac_tx_en, i_mac_txd, i_strap};
            sync2  <= sync1;
            xtal_d <= sync2[8];
        end
    end

    assign xtal_s  = sync2[8];
    assign tx_en_s = sync2[7];
    assign txd_s   = sync2[6:3];
    assign strap_s = strap_t'(sync2[2:0]);

    // Boot sequencing after reset release
    logic [BOOT_W-1:0] boot_cnt, next_boot_cnt;
    strap_t            strap_q, next_strap_q;
    logic              strap_done, next_strap_done;
    logic              led_oe_n, next_led_oe_n;
    logic              mgmt_rdy, next_mgmt_rdy;

    // The warm reset itself is the host's to time; nothing here measures it.
    // Boot counter saturates at the management wait
    always_comb begin
        next_boot_cnt   = boot_cnt;
        next_strap_q    = strap_q;
        next_strap_done = strap_done;
        if (boot_cnt != BOOT_W'(MGMT_WAIT_CYC)) begin
            next_boot_cnt = boot_cnt + 14'h1;
        end
        // R11 latch at release
        if (!strap_done && boot_cnt == STRAP_SAMPLE_CYC) begin
            next_strap_q    = strap_s;
            next_strap_done = 1'b1;
        end
        // R13 pin stays input
        next_led_oe_n = !(strap_done && boot_cnt >= STRAP_SAMPLE_CYC + STRAP_HOLD_CYC);
        // R12 management wait flag
        next_mgmt_rdy = (boot_cnt == BOOT_W'(MGMT_WAIT_CYC));
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            boot_cnt   <= '0;
            strap_q    <= STRAP_RESET;
            strap_done <= 1'b0;
            led_oe_n   <= 1'b1;
            mgmt_rdy   <= 1'b0;
        end else begin
            boot_cnt   <= next_boot_cnt;
            strap_q    <= next_strap_q;
            strap_done <= next_strap_done;
            led_oe_n   <= next_led_oe_n;
            mgmt_rdy   <= next_mgmt_rdy;
        end
    end

    // Clock generation: MII divider and reduced-pin reference
    logic [CNT_W-1:0] div_cnt, next_div_cnt, half;
    logic             mii_clk, next_mii_clk;
    logic             speed_eff, next_speed_eff, speed_sel;
    logic             ref_clk, next_ref_clk;
    logic             mii_rise, ref_tick, xfer;

    assign speed_sel = i_link_up ? i_link_speed_100 : strap_q.speed_100;
    assign half      = speed_eff ? HALF100_CYC : HALF10_CYC;
    assign mii_rise  = (div_cnt == half - 10'h1) && !mii_clk;
    // R9 edges of the external reference
    assign ref_tick  = strap_q.ref50 ? (xtal_s && !xtal_d) : (next_ref_clk && !ref_clk);
    assign xfer      = strap_q.rmii ? ref_tick : mii_rise;

    always_comb begin
        next_div_cnt   = div_cnt + 10'h1;
        next_mii_clk   = mii_clk;
        next_speed_eff = speed_eff;
        // R1 even half periods
        if (div_cnt == half - 10'h1) begin
            next_div_cnt = '0;
            next_mii_clk = !mii_clk;
            // R14 speed switch only at period start, so no runt phase
            if (!mii_clk) begin
                next_speed_eff = speed_sel;
            end
        end
        // R8 toggle every cycle for a 20 ns reference
        next_ref_clk = (strap_q.rmii && !strap_q.ref50) ? !ref_clk : 1'b0;
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_cnt   <= '0;
            mii_clk   <= 1'b0;
            speed_eff <= STRAP_RESET.speed_100;
            ref_clk   <= 1'b0;
        end else begin
            div_cnt   <= next_div_cnt;
            mii_clk   <= next_mii_clk;
            speed_eff <= next_speed_eff;
            ref_clk   <= next_ref_clk;
        end
    end

    // R2 receive clock shares the transmit divider
    assign o_mii_tx_clk   = mii_clk;
    assign o_mii_rx_clk   = mii_clk;
    assign o_rmii_ref_clk = ref_clk;
    assign o_led_speed    = speed_eff;
    assign o_led_speed_oe_n = led_oe_n;
    assign o_mgmt_ready   = mgmt_rdy;

    // Transmit capture; dibits pair low first in reduced-pin mode
    line_nib_t  line_tx, next_line_tx;
    logic       line_tx_valid, next_line_tx_valid;
    logic       tx_phase, next_tx_phase;
    logic [1:0] tx_low, next_tx_low;

    always_comb begin
        next_line_tx       = line_tx;
        next_line_tx_valid = 1'b0;
        next_tx_phase      = tx_phase;
        next_tx_low        = tx_low;
        // R3 capture at the rising edge
        if (xfer && tx_en_s) begin
            if (!strap_q.rmii) begin
                next_line_tx       = '{err: 1'b0, data: txd_s};
                next_line_tx_valid = 1'b1;
            end else if (!tx_phase) begin
                next_tx_low   = txd_s[1:0];
                next_tx_phase = 1'b1;
            end else begin
                next_line_tx       = '{err: 1'b0, data: {txd_s[1:0], tx_low}};
                next_line_tx_valid = 1'b1;
                next_tx_phase      = 1'b0;
            end
        end
        if (!tx_en_s) begin
            next_tx_phase = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            line_tx       <= '0;
            line_tx_valid <= 1'b0;
            tx_phase      <= 1'b0;
            tx_low        <= 2'h0;
        end else begin
            line_tx       <= next_line_tx;
            line_tx_valid <= next_line_tx_valid;
            tx_phase      <= next_tx_phase;
            tx_low        <= next_tx_low;
        end
    end

    assign o_line_tx       = line_tx;
    assign o_line_tx_valid = line_tx_valid;

    // Carrier sense: one counter runs while enable and carrier disagree
    logic [CNT_W-1:0] crs_cnt, next_crs_cnt, crs_lim;
    logic             crs_tx, next_crs_tx, crs, next_crs;

    // R5 R6 speed-dependent latency
    assign crs_lim = speed_eff ? CRS100_CYC : (tx_en_s ? CRS10_ON_CYC : CRS10_OFF_CYC);

    always_comb begin
        next_crs_tx  = crs_tx;
        next_crs_cnt = '0;
        if (tx_en_s != crs_tx) begin
            if (crs_cnt == crs_lim - 10'h1) begin
                next_crs_tx = tx_en_s;
            end else begin
                next_crs_cnt = crs_cnt + 10'h1;
            end
        end
        next_crs = crs_tx || i_line_carrier;
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            crs_cnt <= '0;
            crs_tx  <= 1'b0;
            crs     <= 1'b0;
        end else begin
            crs_cnt <= next_crs_cnt;
            crs_tx  <= next_crs_tx;
            crs     <= next_crs;
        end
    end

    assign o_crs = crs;

    // Receive path: media nibbles buffer until the latency has passed
    rx_state_t        rx_state, next_rx_state;
    logic [CNT_W-1:0] rx_cnt, next_rx_cnt, rx_lat;
    logic             rx_phase, next_rx_phase, pop, f_valid;
    mii_rx_t          mii_rx, next_mii_rx;
    line_nib_t        f_data;

    fifo_buf #(
        .WIDTH ($bits(line_nib_t)),
        .DEPTH (RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_valid   (i_line_rx_valid),
        .o_ready   (o_line_rx_ready),
        .i_data    (i_line_rx),
        .o_valid   (f_valid),
        .i_ready   (pop),
        .o_data    (f_data)
    );

    assign rx_lat = speed_eff ? RX100_LAT_CYC : RX10_LAT_CYC;

    always_comb begin
        next_rx_state = rx_state;
        next_rx_cnt   = rx_cnt;
        next_rx_phase = rx_phase;
        next_mii_rx   = mii_rx;
        pop           = 1'b0;
        unique case (rx_state)
            RX_IDLE: begin
                next_rx_cnt = '0;
                if (crs && i_line_carrier) begin
                    next_rx_state = RX_WAIT;
                end
            end
            // R7 latency from carrier sense
            RX_WAIT: begin
                if (!i_line_carrier) begin
                    next_rx_state = RX_IDLE;
                end else if (rx_cnt == rx_lat - 10'h1) begin
                    next_rx_state = RX_DATA;
                end else begin
                    next_rx_cnt = rx_cnt + 10'h1;
                end
            end
            RX_DATA: begin
                // R4 launch with the clock edge
                if (xfer) begin
                    if (f_valid) begin
                        next_mii_rx.dv = 1'b1;
                        next_mii_rx.er = f_data.err;
                        if (!strap_q.rmii) begin
                            next_mii_rx.data = f_data.data;
                            pop              = 1'b1;
                        end else begin
                            next_mii_rx.data = {2'h0, rx_phase ? f_data.data[3:2] : f_data.data[1:0]};
                            pop              = rx_phase;
                            next_rx_phase    = !rx_phase;
                        end
                    end else begin
                        // Underrun or end of frame drops valid
                        next_mii_rx   = MII_RX_RESET;
                        next_rx_phase = 1'b0;
                        if (!i_line_carrier) begin
                            next_rx_state = RX_IDLE;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_state <= RX_IDLE;
            rx_cnt   <= '0;
            rx_phase <= 1'b0;
            mii_rx   <= MII_RX_RESET;
        end else begin
            rx_state <= next_rx_state;
            rx_cnt   <= next_rx_cnt;
            rx_phase <= next_rx_phase;
            mii_rx   <= next_mii_rx;
        end
    end

    assign o_mii_rx = mii_rx;

    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    a_mii_half_period: assert property ( // R1
        (mii_clk != $past(mii_clk)) |-> $past(div_cnt) == ($past(speed_eff) ? HALF100_CYC : HALF10_CYC) - 10'h1
    ) else $error("mii clock half period wrong");

    a_rx_clk_fast: assert property ( // R2
        $rose(o_mii_rx_clk) && speed_eff |-> o_mii_rx_clk ##1 o_mii_rx_clk ##1 !o_mii_rx_clk
    ) else $error("rx clock high phase not 20 ns");

    a_tx_capture: assert property ( // R3
        !strap_q.rmii && xfer && tx_en_s |=> o_line_tx_valid && o_line_tx.data == $past(txd_s)
    ) else $error("tx nibble not captured");

    a_rx_launch_edge: assert property ( // R4
        !$past(xfer) |-> $stable(o_mii_rx)
    ) else $error("rx outputs moved off clock edge");

    a_crs10_on: assert property ( // R5
        $rose(crs_tx) && !$past(speed_eff) |-> $past(crs_cnt) == CRS10_ON_CYC - 10'h1
    ) else $error("10M carrier rise latency wrong");

    a_crs10_off: assert property ( // R5
        $fell(crs_tx) && !$past(speed_eff) |-> $past(crs_cnt) == CRS10_OFF_CYC - 10'h1
    ) else $error("10M carrier fall latency wrong");

    a_crs100_rise: assert property ( // R6
        ($rose(tx_en_s) && speed_eff) ##1 (tx_en_s && speed_eff) [*7] |=> crs_tx
    ) else $error("100M carrier not up after 72 ns");

    a_rx_latency: assert property ( // R7
        rx_state == RX_DATA && $past(rx_state) == RX_WAIT |-> $past(rx_cnt) == $past(rx_lat) - 10'h1
    ) else $error("receive latency wrong");

    a_ref_toggle: assert property ( // R8
        strap_q.rmii && !strap_q.ref50 && $stable(strap_q) |=> o_rmii_ref_clk != $past(o_rmii_ref_clk)
    ) else $error("reference clock not 50 MHz");

    a_strap_latch: assert property ( // R11
        $rose(strap_done) |-> strap_q == $past(strap_s) && $past(boot_cnt) == STRAP_SAMPLE_CYC
    ) else $error("straps not latched at release");

    a_strap_hold: assert property ( // R13
        (boot_cnt <= STRAP_SAMPLE_CYC + STRAP_HOLD_CYC) |-> o_led_speed_oe_n
    ) else $error("strap pin driven too early");

    a_speed_commit: assert property ( // R14
        $changed(speed_eff) |-> $rose(o_mii_tx_clk)
    ) else $error("speed changed mid clock period");

    c_crs_up:   cover property ($rose(o_crs));
    c_rx_frame: cover property ($rose(o_mii_rx.dv) ##[1:40] $fell(o_mii_rx.dv));
    c_rmii_tx:  cover property (o_line_tx_valid && strap_q.rmii);
    c_fifo_full: cover property (i_line_rx_valid && !o_line_rx_ready);

endmodule // phy_mii_port

// ### shared/phy_port_pkg.sv
// Summary of operation
// R1 - Transmit clock period 400 ns at 10 Mbps, 40 ns at 100 Mbps, even duty.
// R2 - Receive clock period 400 ns at 10 Mbps, 40 ns at 100 Mbps, even duty.
// R3 - Transmit nibble and enable are captured on each transmit clock rising edge.
// R4 - Receive valid, nibble and error launch from the receive clock rising edge.
// R5 - At 10 Mbps carrier sense rises 600 ns after enable, falls 1.0 us after.
// R6 - At 100 Mbps carrier sense follows transmit enable by 72 ns both ways.
// R7 - Receive data starts 7.2 us (10 Mbps) or 170 ns (100 Mbps) after carrier.
// R8 - With a 25 MHz crystal input, drive a 50 MHz, 20 ns reference clock out.
// R9 - With a 50 MHz crystal input, time all reduced-pin transfers from it.
// R10 - The host holds reset low at least 500 us for a warm reset.
// R11 - Straps are sampled and applied only when reset is released.
// R12 - Management access waits at least 100 us after reset release.
// R13 - Dual-purpose strap pins stay inputs at least 6 ns after reset release.
// R14 - Clock rates and latencies follow the speed in effect; clocks keep running.
package phy_port_pkg;

    // Own clock
    localparam int CLK_NS = 10;

    // Link timing in nanoseconds
    localparam int MII10_NS      = 400;
    localparam int MII100_NS     = 40;
    localparam int CRS10_ON_NS   = 600;
    localparam int CRS10_OFF_NS  = 1000;
    localparam int CRS100_NS     = 72;
    localparam int RX10_LAT_NS   = 7200;
    localparam int RX100_LAT_NS  = 170;
    localparam int STRAP_HOLD_NS = 6;

    // Reset timing in microseconds
    localparam int WARM_RST_US  = 500;
    localparam int MGMT_WAIT_US = 100;

    localparam int CNT_W  = 10;
    localparam int BOOT_W = 14;

    // Cycle counts; latencies and strap hold rounded up to whole cycles
    localparam logic [CNT_W-1:0] HALF10_CYC    = CNT_W'(MII10_NS / (2 * CLK_NS));
    localparam logic [CNT_W-1:0] HALF100_CYC   = CNT_W'(MII100_NS / (2 * CLK_NS));
    localparam logic [CNT_W-1:0] CRS10_ON_CYC  = CNT_W'((CRS10_ON_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] CRS10_OFF_CYC = CNT_W'((CRS10_OFF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] CRS100_CYC    = CNT_W'((CRS100_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RX10_LAT_CYC  = CNT_W'((RX10_LAT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RX100_LAT_CYC = CNT_W'((RX100_LAT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [BOOT_W-1:0] STRAP_SAMPLE_CYC = 14'h2;
    localparam logic [BOOT_W-1:0] STRAP_HOLD_CYC   = BOOT_W'((STRAP_HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam int MGMT_WAIT_DEF = MGMT_WAIT_US * 1000 / CLK_NS;

    // Receive buffer
    localparam int RX_FIFO_DEPTH = 4;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_WAIT = 3'b010,
        RX_DATA = 3'b100
    } rx_state_t;

    typedef struct packed {
        logic ref50;
        logic rmii;
        logic speed_100;
    } strap_t;

    typedef struct packed {
        logic       err;
        logic [3:0] data;
    } line_nib_t;

    typedef struct packed {
        logic       dv;
        logic       er;
        logic [3:0] data;
    } mii_rx_t;

    localparam strap_t STRAP_RESET = '{ref50: 1'b0, rmii: 1'b0, speed_100: 1'b1};
    localparam mii_rx_t MII_RX_RESET = '{dv: 1'b0, er: 1'b0, data: 4'h0};

endpackage

// ### tb/mac_model.sv
`timescale 1ns/1ps
module mac_model (
    input  logic                  i_tx_clk,
    input  logic                  i_rx_clk,
    input  phy_port_pkg::mii_rx_t i_mii_rx,
    output logic [3:0]            o_txd,
    output logic                  o_tx_en
);
    import phy_port_pkg::*;
    logic [3:0] tx_q[$];
    logic [4:0] rx_q[$];
    initial begin
        o_txd = 4'h0;
        o_tx_en = 1'b0;
    end
    always @(posedge i_tx_clk) begin
        if (tx_q.size() > 0) begin
            o_txd <= tx_q.pop_front();
            o_tx_en <= 1'b1;
        end else begin
            o_txd <= ~o_txd; // Idle data keeps moving, never a stale nibble
            o_tx_en <= 1'b0;
        end
    end
    // sample what the last rise launched; the falling edge avoids a race with the launch
    always @(negedge i_rx_clk) begin
        if (i_mii_rx.dv === 1'b1) begin
            rx_q.push_back({i_mii_rx.er, i_mii_rx.data});
        end
    end
endmodule // mac_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import phy_port_pkg::*;
    localparam int MW = 20;
    logic      clk, rstn, xtal, lup, l100, car, rxv, txc, rxc, refc, txv, rdy, led, oe_n, mrdy, crs, tx_en;
    logic [3:0] txd;
    strap_t    strap;
    mii_rx_t   rx_out;
    line_nib_t tx_line, rx_line;
    logic [3:0] sent[$];
    logic [4:0] got[$];
    logic [4:0] pushed[$];
    int        n_fail, checks_done;

    phy_mii_port #(.MGMT_WAIT_CYC(MW)) u_phy_mii_port (.i_ref_clk(clk), .i_rstn(rstn),
        .i_crystal_clock_input(xtal), .i_strap(strap), .i_link_up(lup), .i_link_speed_100(l100),
        .i_mac_txd(txd), .i_mac_tx_en(tx_en), .o_mii_tx_clk(txc), .o_mii_rx_clk(rxc),
        .o_rmii_ref_clk(refc), .o_mii_rx(rx_out), .o_crs(crs), .o_line_tx(tx_line),
        .o_line_tx_valid(txv), .i_line_carrier(car), .i_line_rx_valid(rxv), .i_line_rx(rx_line),
        .o_line_rx_ready(rdy), .o_led_speed(led), .o_led_speed_oe_n(oe_n), .o_mgmt_ready(mrdy));
    // Reduced-pin MAC runs on the shared reference: generated, or the external one
    mac_model u_mac_model (.i_tx_clk(strap.rmii ? (strap.ref50 ? xtal : refc) : txc), .i_rx_clk(rxc),
        .i_mii_rx(rx_out), .o_txd(txd), .o_tx_en(tx_en));

    // Clocks: link clock free of the system clock's phase
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        xtal = 1'b0;
        #3;
        forever #40 xtal = ~xtal;
    end
    // Capture monitor for line transmit pulses
    always @(posedge clk) begin
        if (txv === 1'b1) got.push_back(tx_line);
    end

    task automatic finish_test();
        $display("errors %0d checks %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic check_rng(input string nm, input int lo, input int hi, input int g);
        checks_done++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Observed outputs picked by index, avoids ref to port nets
    function automatic logic sel(input int k);
        case (k)
            0: return txc;
            1: return rxc;
            2: return refc;
            3: return crs;
            4: return tx_en;
            5: return rx_out.dv;
            default: return mrdy;
        endcase
    endfunction
    task automatic wait_lvl(input int k, input logic v, output int n);
        n = 0;
        while (sel(k) !== v && n < 3000) begin
            tick(1);
            n++;
        end
    endtask
    task automatic chk_clk(input int k, input int half, input string nm);
        int n, h, l;
        wait_lvl(k, 1'b0, n);
        wait_lvl(k, 1'b1, n);
        wait_lvl(k, 1'b0, h);
        wait_lvl(k, 1'b1, l);
        check(nm, half, h);
        check(nm, half, l);
    endtask
    // warm reset held low, scaled down
    task automatic do_reset(input strap_t s);
        strap = s;
        rstn = 1'b0;
        tick(12);
        rstn = 1'b1;
    endtask
    // One frame from the MAC: carrier latency both ways, then captured nibbles
    task automatic tx_frame(input int nn, input int on_c, input int off_c, input bit rm);
        int n;
        logic [3:0] v;
        for (int i = 0; i < nn; i++) begin
            v = 4'($urandom);
            sent.push_back(v);
            if (rm) begin
                // Reduced-pin: low dibit first, then high
                u_mac_model.tx_q.push_back({2'h0, v[1:0]});
                u_mac_model.tx_q.push_back({2'h0, v[3:2]});
            end else begin
                u_mac_model.tx_q.push_back(v);
            end
        end
        wait_lvl(4, 1'b1, n);
        wait_lvl(3, 1'b1, n);
        check_rng("crs_on", on_c + 2, on_c + 4, n);
        wait_lvl(4, 1'b0, n);
        wait_lvl(3, 1'b0, n);
        check_rng("crs_off", off_c + 2, off_c + 4, n);
        check("tx_count", sent.size(), got.size());
        foreach (sent[i]) check("tx_nibble", {1'b0, sent[i]}, got[i]);
        sent.delete();
        got.delete();
    endtask

    initial begin
        int n;
        void'($urandom(32'h9C31C2C6));
        {rstn, lup, l100, car, rxv, rx_line} = '0;
        n_fail = 0;
        checks_done = 0;
        do_reset(STRAP_RESET);
        check("strap_oe_n", 1, oe_n);
        tick(3);
        check("strap_oe_n", 1, oe_n);
        tick(5);
        check("strap_oe_n", 0, oe_n);
        wait_lvl(6, 1'b1, n);
        check_rng("mgmt_wait", MW, MW + 2, n + 8);
        check("led_speed", 1, led);
        strap.speed_100 = 1'b0;
        tick(20);
        check("led_speed", 1, led);
        chk_clk(0, 32'(HALF100_CYC), "tx_clk_half");
        chk_clk(1, 32'(HALF100_CYC), "rx_clk_half");
        tx_frame(3, int'(CRS100_CYC), int'(CRS100_CYC), 1'b0);
        lup = 1'b1;
        tick(100);
        check("led_speed", 0, led);
        chk_clk(0, 32'(HALF10_CYC), "tx_clk_half");
        chk_clk(1, 32'(HALF10_CYC), "rx_clk_half");
        tx_frame(3, int'(CRS10_ON_CYC), int'(CRS10_OFF_CYC), 1'b0);
        l100 = 1'b1;
        tick(100);
        // Fill the receive buffer until it refuses, then open the frame
        for (int i = 0; i < RX_FIFO_DEPTH; i++) begin
            rxv = 1'b1;
            rx_line = 5'($urandom);
            pushed.push_back(rx_line);
            do @(posedge clk); while (rdy !== 1'b1);
            #1;
        end
        rxv = 1'b0;
        tick(1);
        check("rx_ready_full", 0, rdy);
        car = 1'b1;
        wait_lvl(3, 1'b1, n);
        wait_lvl(5, 1'b1, n);
        check_rng("rx_latency", int'(RX100_LAT_CYC), int'(RX100_LAT_CYC) + 2 * int'(HALF100_CYC) + 3, n);
        tick(40);
        car = 1'b0;
        check("rx_count", pushed.size(), u_mac_model.rx_q.size());
        foreach (pushed[i]) check("rx_nibble", pushed[i], u_mac_model.rx_q[i]);
        check("rx_ready_empty", 1, rdy);
        lup = 1'b0;
        do_reset('{ref50: 1'b0, rmii: 1'b1, speed_100: 1'b0});
        tick(10);
        chk_clk(2, 1, "ref_clk_half");
        check("led_speed", 0, led);
        chk_clk(0, 32'(HALF10_CYC), "tx_clk_half");
        tx_frame(20, int'(CRS10_ON_CYC), int'(CRS10_OFF_CYC), 1'b1);
        do_reset('{ref50: 1'b1, rmii: 1'b1, speed_100: 1'b1});
        tick(10);
        check("ref_clk_off", 0, refc);
        tx_frame(3, int'(CRS100_CYC), int'(CRS100_CYC), 1'b1);
        finish_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        finish_test();
    end
endmodule // tb_top
